// >>> dv/iie_contact_model.sv
// field contact model: levels set by the bench, with a short bounce on change
`timescale 1ns/1ps
module iie_contact_model (
    input  wire logic       CLK_I,
    input  wire logic [7:0] level_i,  // commanded contact levels
    output logic      [7:0] pin_o     // levels seen at the pins
);
    logic [7:0] lv_q  = 8'h0;  // settled level
    logic [7:0] chg_q = 8'h0;  // bits that just moved
    logic [1:0] bn_q  = 2'h0;  // bounce age
    always_ff @(posedge CLK_I) begin
        if (level_i != lv_q) begin
            chg_q <= level_i ^ lv_q;
            lv_q  <= level_i;
            bn_q  <= 2'h3;
        end else if (bn_q != 2'h0) begin
            bn_q <= bn_q - 2'h1;
        end
    end
    // one cycle back at the old level, only on moved bits
    assign pin_o = lv_q ^ ((bn_q == 2'h2) ? chg_q : 8'h0);
endmodule

// >>> dv/iie_input_event_chk.sv
// bus and state checks for the input event block
`timescale 1ns/1ps
module iie_input_event_chk (
    input wire logic        CLK_I,
    input wire logic        RST_B_I,
    input wire logic        CE_I,
    input wire logic [7:0]  ISOLATED_INPUT_N_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [2:0]  HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic        IRQ_O,
    input wire logic [7:0]  INPUT_CHANNEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic take;     // transfer accepted this edge
    logic wr_dp_q;  // write data phase, frozen with the clock enable
    assign take = HSEL_I & HREADY_I & HTRANS_I[1] & CE_I;
    // write data phase tracker
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            wr_dp_q <= 1'h0;
        end else if (CE_I) begin
            wr_dp_q <= take & HWRITE_I;
        end
    end
    okay_resp_a: assert property (HRESP_O == 1'h0) else $error("error response seen");
    rd_wait_a: assert property (take && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O) else $error("read wait wrong");
    wr_nowait_a: assert property (take && HWRITE_I |=> HREADYOUT_O) else $error("write stalled");
    one_wait_a: assert property (!HREADYOUT_O |=> HREADYOUT_O) else $error("wait state too long");
    rst_clear_a: assert property ($rose(RST_B_I) |-> !IRQ_O && INPUT_CHANNEL_O == 8'h0 && HRDATA_O == 32'h0)
        else $error("reset state wrong");
    chan_quiet_a: assert property ((ISOLATED_INPUT_N_I == INPUT_CHANNEL_O) [*4] |=> $stable(INPUT_CHANNEL_O))
        else $error("state moved without input");
    rdata_hold_a: assert property ($changed(HRDATA_O) |-> $past(HREADYOUT_O) == 1'h0) else $error("read data moved");
    irq_fall_a: assert property ($fell(IRQ_O) |-> $past(wr_dp_q)) else $error("irq dropped unasked");
    ce_freeze_a: assert property (!CE_I |=> $stable(INPUT_CHANNEL_O) && $stable(IRQ_O)) else $error("moved while frozen");
    cover property (take && !HWRITE_I);
    cover property ($rose(IRQ_O));
    cover property ($changed(INPUT_CHANNEL_O));
endmodule

// >>> dv/testbench.sv
// self-checking bench for the input event block
`timescale 1ns/1ps
`include "iie_consts.svh"
module testbench;
    logic        clk    = 1'h0;   // 40 MHz clock
    logic        rst_b  = 1'h0;   // reset, active low
    logic        ce     = 1'h1;   // clock enable
    logic        hwrite = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr  = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdq;     // read data, value taken
    logic        hrdyo, hresp, irq;
    logic [7:0]  lvl    = 8'h0;   // contact command
    logic [7:0]  pin, chan, v, m, p;
    int          error_cnt = 0;
    int          n_tests   = 0;
    // counter set-up: edges, enables, irq causes, reset and match values
    logic [7:0]  cfg_a [8] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h84, 8'hA0, 8'h24};
    logic [31:0] cfg_d [8] = '{32'h7, 32'h4, 32'h7, 32'h2, 32'h1, 32'hFFFE, 32'h3, 32'h7};
    // short filter interval keeps the run brief
    iie_input_event #(.FILT_CYC(20)) dut_u (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
        .ISOLATED_INPUT_N_I(pin), .HSEL_I(1'h1), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdyo),
        .HRDATA_O(hrdata), .HREADYOUT_O(hrdyo), .HRESP_O(hresp), .IRQ_O(irq), .INPUT_CHANNEL_O(chan));
    iie_contact_model sw_u (.CLK_I(clk), .level_i(lvl), .pin_o(pin));
    // clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // ready is read mid-cycle so the edge never races the design
    task automatic rdy;
        logic r;
        do begin
            @(negedge clk);
            r = hrdyo;
            rdq = hrdata;
            @(posedge clk);
        end while (r !== 1'h1);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(rdq, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [15:0] cnt_exp(input logic [15:0] r, input int n);
        return r + n[15:0];
    endfunction
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog, well past the expected run
    initial begin
        #2250000;
        error_cnt++;
        test_done();
    end
    initial begin
        void'($urandom(32'h8e1884c1));
        cyc(4);
        rst_b <= 1'h1;
        rd(8'h40, `IIE_SAMP_RST);
        rd(8'h7C, `IIE_SAMP_RST);
        rd(8'hA0, `IIE_MAT_RST_VAL);
        rd(8'hC0, `IIE_CNT_RST_VAL);
        rd(8'hFC, 32'h0);
        // unfiltered change of state with its interrupt
        bus(1'h1, 8'h0C, 32'hFF);
        bus(1'h1, 8'h3C, 32'h2);
        v = 8'($urandom) | 8'h1;
        lvl <= v;
        cyc(4100);
        chk(chan, v);
        rd(8'h28, {24'h0, v});
        chk(irq, 1'h1);
        rd(8'h30, {24'h0, v});
        bus(1'h1, 8'h30, 32'hFF);
        cyc(1);
        chk(irq, 1'h0);
        // pattern match, unselected channels random
        m = 8'($urandom) | 8'h1;
        p = 8'($urandom);
        lvl <= ~p;
        cyc(4100);
        bus(1'h1, 8'h04, {24'h0, m});
        bus(1'h1, 8'h08, {24'h0, p});
        bus(1'h1, 8'h3C, 32'h1);
        bus(1'h1, 8'h2C, 32'h1);
        rd(8'h2C, 32'h0);
        lvl <= (p & m) | (8'($urandom) & ~m);
        cyc(4100);
        rd(8'h2C, 32'h1);
        chk(irq, 1'h1);
        // counters: rising on 0 and 1, both edges on 2, wrap and match
        bus(1'h1, 8'h3C, 32'hC);
        lvl <= 8'h0;
        cyc(4100);
        foreach (cfg_a[i]) bus(1'h1, cfg_a[i], cfg_d[i]);
        repeat (3) begin
            lvl <= 8'h7;
            cyc(4100);
            lvl <= 8'h0;
            cyc(4100);
        end
        rd(8'hC0, 32'h3);
        rd(8'hC4, {16'h0, cnt_exp(16'hFFFE, 3)});
        rd(8'hC8, 32'h6);
        rd(8'h38, 32'h1);
        rd(8'h34, 32'h2);
        chk(irq, 1'h1);
        // filtered channel 3: high after four samples, low after two
        bus(1'h1, 8'h4C, 32'h3);
        bus(1'h1, 8'h6C, 32'h1);
        bus(1'h1, 8'h00, 32'h8);
        lvl <= 8'h8;
        cyc(50);
        chk(chan[3], 1'h0);
        cyc(80);
        chk(chan[3], 1'h1);
        lvl <= 8'h0;
        cyc(15);
        chk(chan[3], 1'h1);
        cyc(75);
        chk(chan[3], 1'h0);
        ce <= 1'h0;
        cyc(6);
        ce <= 1'h1;
        cyc(2);
        test_done();
    end
endmodule
bind iie_input_event iie_input_event_chk chk_u (.*);

// >>> src/iie_consts.svh
// constants for the isolated input event block: offsets, fields, resets, timing
`ifndef IIE_CONSTS_SVH
`define IIE_CONSTS_SVH

// ----------------------------------------------------------------
// channel and field sizes
// ----------------------------------------------------------------
`define IIE_NCH          8
`define IIE_CW           16

// ----------------------------------------------------------------
// scalar register byte offsets
// ----------------------------------------------------------------
`define IIE_OFF_FILT_EN  8'h00
`define IIE_OFF_PAT_EN   8'h04
`define IIE_OFF_PAT_VAL  8'h08
`define IIE_OFF_COS_EN   8'h0C
`define IIE_OFF_RISE_EN  8'h10
`define IIE_OFF_FALL_EN  8'h14
`define IIE_OFF_CNT_EN   8'h18
`define IIE_OFF_OVF_IE   8'h1C
`define IIE_OFF_MAT_IE   8'h20
`define IIE_OFF_CNT_RST  8'h24
`define IIE_OFF_STATE    8'h28
`define IIE_OFF_PAT_FLG  8'h2C
`define IIE_OFF_COS_FLG  8'h30
`define IIE_OFF_OVF_FLG  8'h34
`define IIE_OFF_MAT_FLG  8'h38
`define IIE_OFF_IRQ_EN   8'h3C

// ----------------------------------------------------------------
// per-channel register groups: byte address bits [7:5], channel in [4:2]
// ----------------------------------------------------------------
`define IIE_GRP_HIGH     3'h2
`define IIE_GRP_LOW      3'h3
`define IIE_GRP_RSTV     3'h4
`define IIE_GRP_MATV     3'h5
`define IIE_GRP_COUNT    3'h6

// ----------------------------------------------------------------
// irq enable field positions
// ----------------------------------------------------------------
`define IIE_IE_PAT       0
`define IIE_IE_COS       1
`define IIE_IE_OVF       2
`define IIE_IE_MAT       3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IIE_SAMP_RST     16'h0002
`define IIE_CNT_RST_VAL  16'h0000
`define IIE_MAT_RST_VAL  16'hFFFF

// ----------------------------------------------------------------
// timing: rate, sample intervals and derived cycle counts
// ----------------------------------------------------------------
`define IIE_CLK_HZ       40000000
`define IIE_FAST_US      100
`define IIE_FILT_MS      5
`define IIE_FAST_CYC     ((`IIE_CLK_HZ / 1000000) * `IIE_FAST_US)
`define IIE_FILT_CYC     ((`IIE_CLK_HZ / 1000) * `IIE_FILT_MS)

`endif

// >>> src/iie_input_event.sv
// isolated input event logic: filters, pattern match, change of state, counters
//
// Behaviour
// (RULE1) eight channels, each with full own logic
// (RULE2) filtered state changes only after qualification
// (RULE3) high accepted after count plus one samples
// (RULE4) low accepted after own count plus one
// (RULE5) filter, pattern, change irq enabled per channel
// (RULE6) selected channels matching pattern raise interrupt
// (RULE7) pattern preset programmable, compared continuously
// (RULE8) any enabled channel change raises interrupt
// (RULE9) each channel owns sixteen bit counter
// (RULE10) count rising, falling or both edges
// (RULE11) interrupt on wrap and on match
// (RULE12) counts 500 Hz inputs correctly
// (RULE13) filtered channels sampled every 5 ms
// (RULE14) unfiltered channels sampled every 100 us
// (RULE15) unselected channels ignored by pattern match
// (RULE16) reset command loads programmable reset value
// (RULE17) sticky flags, irq while enabled flag set
// (RULE18) inputs synchronised before filter and edges
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "iie_consts.svh"

module iie_input_event #(
    parameter int unsigned FILT_CYC = `IIE_FILT_CYC
) (
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        CE_I,
    input  wire logic [7:0]  ISOLATED_INPUT_N_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic             IRQ_O,
    output logic      [7:0]  INPUT_CHANNEL_O
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam logic [11:0] FAST_LAST = 12'(`IIE_FAST_CYC - 1);  // 100 us prescaler end
    localparam logic [17:0] FILT_LAST = 18'(FILT_CYC - 1);       // 5 ms prescaler end

    logic [7:0]  sync1_q, sync1_d;          // first sync stage, read only by stage two
    logic [7:0]  sync2_q, sync2_d;          // sampled level seen by the logic
    logic [11:0] fast_q, fast_d;            // 100 us prescaler
    logic [17:0] filt_q, filt_d;            // 5 ms prescaler
    logic        fast_tick;                 // one cycle per 100 us
    logic        filt_tick;                 // one cycle per 5 ms
    logic [7:0]  chan_st;                   // qualified channel states
    logic [7:0]  chg;                       // state changes this cycle
    logic [7:0]  ovf_ev, mat_ev;            // counter events
    logic [7:0]  cnt_load;                  // counter reset command pulses
    iie_pkg::iie_word_type cnt_val [8];     // live counter values

    logic [7:0]  filt_en_q, filt_en_d, pat_en_q, pat_en_d, pat_val_q, pat_val_d;
    logic [7:0]  cos_en_q, cos_en_d, rise_en_q, rise_en_d, fall_en_q, fall_en_d;
    logic [7:0]  cnt_en_q, cnt_en_d, ovf_ie_q, ovf_ie_d, mat_ie_q, mat_ie_d;
    logic [7:0]  cos_flg_q, cos_flg_d, ovf_flg_q, ovf_flg_d, mat_flg_q, mat_flg_d;
    logic        pat_flg_q, pat_flg_d;      // sticky pattern match flag
    logic        pat_prev_q, pat_prev_d;    // match level last cycle
    logic        pat_now;                   // combinational match level
    logic [3:0]  irq_en_q, irq_en_d;        // per cause irq enables
    iie_pkg::iie_word_type high_q [8], high_d [8];   // high sample counts
    iie_pkg::iie_word_type low_q  [8], low_d  [8];   // low sample counts
    iie_pkg::iie_word_type rstv_q [8], rstv_d [8];   // counter reset values
    iie_pkg::iie_word_type matv_q [8], matv_d [8];   // counter match values

    iie_pkg::iie_phase_type phase_q, phase_d;        // bus slave phase
    logic [7:0]  addr_q, addr_d;            // captured byte address
    logic [31:0] rdata_q, rdata_d;          // read data register
    logic        wr_act;                    // write data phase now
    logic [31:0] w1c;                       // write-one-to-clear mask

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // only the low 256 bytes decode; anything above reads zero
    function automatic logic addr_ok(input logic [31:0] a);
        addr_ok = (a[31:8] == 24'h000000) && (a[1:0] == 2'b00);
    endfunction

    // read multiplexer over the whole map
    function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] st,
                                           input logic [7:0] cf, input logic [7:0] of,
                                           input logic [7:0] mf, input logic pf);
        rd_mux = 32'h00000000;
        case (a[7:5])
            `IIE_GRP_HIGH:  rd_mux = {16'h0000, high_q[a[4:2]]};
            `IIE_GRP_LOW:   rd_mux = {16'h0000, low_q[a[4:2]]};
            `IIE_GRP_RSTV:  rd_mux = {16'h0000, rstv_q[a[4:2]]};
            `IIE_GRP_MATV:  rd_mux = {16'h0000, matv_q[a[4:2]]};
            `IIE_GRP_COUNT: rd_mux = {16'h0000, cnt_val[a[4:2]]};
            default: begin
                case (a)
                    `IIE_OFF_FILT_EN: rd_mux = {24'h000000, filt_en_q};
                    `IIE_OFF_PAT_EN:  rd_mux = {24'h000000, pat_en_q};
                    `IIE_OFF_PAT_VAL: rd_mux = {24'h000000, pat_val_q};
                    `IIE_OFF_COS_EN:  rd_mux = {24'h000000, cos_en_q};
                    `IIE_OFF_RISE_EN: rd_mux = {24'h000000, rise_en_q};
                    `IIE_OFF_FALL_EN: rd_mux = {24'h000000, fall_en_q};
                    `IIE_OFF_CNT_EN:  rd_mux = {24'h000000, cnt_en_q};
                    `IIE_OFF_OVF_IE:  rd_mux = {24'h000000, ovf_ie_q};
                    `IIE_OFF_MAT_IE:  rd_mux = {24'h000000, mat_ie_q};
                    `IIE_OFF_STATE:   rd_mux = {24'h000000, st};
                    `IIE_OFF_PAT_FLG: rd_mux = {31'h00000000, pf};
                    `IIE_OFF_COS_FLG: rd_mux = {24'h000000, cf};
                    `IIE_OFF_OVF_FLG: rd_mux = {24'h000000, of};
                    `IIE_OFF_MAT_FLG: rd_mux = {24'h000000, mf};
                    `IIE_OFF_IRQ_EN:  rd_mux = {28'h0000000, irq_en_q};
                    default:          rd_mux = 32'h00000000;
                endcase
            end
        endcase
    endfunction

    // ----------------------------------------------------------------
    // input synchroniser and sample prescalers
    // ----------------------------------------------------------------
    assign fast_tick = (fast_q == FAST_LAST);
    assign filt_tick = (filt_q == FILT_LAST);

    // next values: two sync stages, free-running tick counters
    always_comb begin
        // (RULE18) two stage sync
        sync1_d = ISOLATED_INPUT_N_I;
        sync2_d = sync1_q;
        // (RULE14) 100 us tick
        fast_d  = fast_tick ? 12'h000 : fast_q + 12'h001;
        // (RULE13) 5 ms tick
        filt_d  = filt_tick ? 18'h00000 : filt_q + 18'h00001;
    end

    // register stage; clock enable freezes everything
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            fast_q  <= 12'h000;
            filt_q  <= 18'h00000;
        end else if (CE_I) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            fast_q  <= fast_d;
            filt_q  <= filt_d;
        end
    end

    // ----------------------------------------------------------------
    // per-channel filter and event counter
    // ----------------------------------------------------------------
    // (RULE1) one copy per channel
    for (genvar g = 0; g < `IIE_NCH; g++) begin : g_ch
        logic                  st_q, st_d;     // qualified state
        iie_pkg::iie_word_type fc_q, fc_d;     // consecutive differing samples
        iie_pkg::iie_word_type ct_q, ct_d;     // event counter
        iie_pkg::iie_word_type lim;            // qualification count for new level
        logic                  inc;            // counted edge this cycle

        assign lim = sync2_q[g] ? high_q[g] : low_q[g];
        assign chg[g]     = st_d ^ st_q;
        assign chan_st[g] = st_q;
        // (RULE10) edge selection
        assign inc = cnt_en_q[g] & ((chg[g] & st_d & rise_en_q[g]) | (chg[g] & ~st_d & fall_en_q[g]));
        assign cnt_val[g] = ct_q;
        // (RULE11) wrap and match events
        assign ovf_ev[g] = inc & ~cnt_load[g] & (ct_q == 16'hFFFF);
        assign mat_ev[g] = inc & ~cnt_load[g] & (ct_d == matv_q[g]);

        // next state of filter and counter
        always_comb begin
            st_d = st_q;
            fc_d = fc_q;
            ct_d = ct_q;
            // (RULE5) filter per channel
            if (filt_en_q[g]) begin
                if (filt_tick) begin
                    // (RULE2) hold until level persists
                    if (sync2_q[g] == st_q) begin
                        fc_d = 16'h0000;
                    // (RULE3) (RULE4) count plus one samples
                    end else if (fc_q == lim) begin
                        st_d = sync2_q[g];
                        fc_d = 16'h0000;
                    end else begin
                        fc_d = fc_q + 16'h0001;
                    end
                end
            end else begin
                // (RULE14) follow at once on fast tick
                fc_d = 16'h0000;
                if (fast_tick) begin
                    st_d = sync2_q[g];
                end
            end
            // (RULE16) reset command wins over counting
            if (cnt_load[g]) begin
                ct_d = rstv_q[g];
            // (RULE9) (RULE12) count each sampled edge, wraps
            end else if (inc) begin
                ct_d = ct_q + 16'h0001;
            end
        end

        // register stage of one channel
        always_ff @(posedge CLK_I) begin
            if (!RST_B_I) begin
                st_q <= 1'b0;
                fc_q <= 16'h0000;
                ct_q <= `IIE_CNT_RST_VAL;
            end else if (CE_I) begin
                st_q <= st_d;
                fc_q <= fc_d;
                ct_q <= ct_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // pattern match level
    // ----------------------------------------------------------------
    // (RULE6) (RULE7) (RULE15) unselected bits forced to match
    assign pat_now = (|pat_en_q) & (&(~pat_en_q | ~(chan_st ^ pat_val_q)));

    // ----------------------------------------------------------------
    // AHB-Lite slave: writes take one data cycle, reads one wait state
    // ----------------------------------------------------------------
    // reads wait a cycle so data is taken from registers already updated
    always_comb begin
        phase_d = phase_q;
        addr_d  = addr_q;
        rdata_d = rdata_q;
        if (phase_q == iie_pkg::IIE_RD1) begin
            phase_d = iie_pkg::IIE_RD2;
            rdata_d = addr_ok({24'h000000, addr_q}) ?
                      rd_mux(addr_q, chan_st, cos_flg_q, ovf_flg_q, mat_flg_q, pat_flg_q) : 32'h00000000;
        end else if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
            // new address phase accepted
            phase_d = HWRITE_I ? iie_pkg::IIE_WR : iie_pkg::IIE_RD1;
            addr_d  = addr_ok(HADDR_I) ? HADDR_I[7:0] : 8'hFC;
        end else begin
            phase_d = iie_pkg::IIE_IDLE;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            phase_q <= iie_pkg::IIE_IDLE;
            addr_q  <= 8'h00;
            rdata_q <= 32'h00000000;
        end else if (CE_I) begin
            phase_q <= phase_d;
            addr_q  <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    assign HRDATA_O    = rdata_q;
    assign HREADYOUT_O = (phase_q != iie_pkg::IIE_RD1);
    assign HRESP_O     = 1'b0;

    // ----------------------------------------------------------------
    // register file and sticky flags
    // ----------------------------------------------------------------
    assign wr_act   = (phase_q == iie_pkg::IIE_WR) && addr_ok({24'h000000, addr_q});
    assign cnt_load = (wr_act && addr_q == `IIE_OFF_CNT_RST) ? HWDATA_I[7:0] : 8'h00;

    // next values: software writes, then hardware events
    always_comb begin
        w1c       = (wr_act) ? HWDATA_I : 32'h00000000;
        filt_en_d = filt_en_q;
        pat_en_d  = pat_en_q;
        pat_val_d = pat_val_q;
        cos_en_d  = cos_en_q;
        rise_en_d = rise_en_q;
        fall_en_d = fall_en_q;
        cnt_en_d  = cnt_en_q;
        ovf_ie_d  = ovf_ie_q;
        mat_ie_d  = mat_ie_q;
        irq_en_d  = irq_en_q;
        high_d    = high_q;
        low_d     = low_q;
        rstv_d    = rstv_q;
        matv_d    = matv_q;
        if (wr_act) begin
            case (addr_q[7:5])
                `IIE_GRP_HIGH: high_d[addr_q[4:2]] = HWDATA_I[15:0];
                `IIE_GRP_LOW:  low_d[addr_q[4:2]]  = HWDATA_I[15:0];
                `IIE_GRP_RSTV: rstv_d[addr_q[4:2]] = HWDATA_I[15:0];
                `IIE_GRP_MATV: matv_d[addr_q[4:2]] = HWDATA_I[15:0];
                default: begin
                    case (addr_q)
                        `IIE_OFF_FILT_EN: filt_en_d = HWDATA_I[7:0];
                        `IIE_OFF_PAT_EN:  pat_en_d  = HWDATA_I[7:0];
                        `IIE_OFF_PAT_VAL: pat_val_d = HWDATA_I[7:0];
                        `IIE_OFF_COS_EN:  cos_en_d  = HWDATA_I[7:0];
                        `IIE_OFF_RISE_EN: rise_en_d = HWDATA_I[7:0];
                        `IIE_OFF_FALL_EN: fall_en_d = HWDATA_I[7:0];
                        `IIE_OFF_CNT_EN:  cnt_en_d  = HWDATA_I[7:0];
                        `IIE_OFF_OVF_IE:  ovf_ie_d  = HWDATA_I[7:0];
                        `IIE_OFF_MAT_IE:  mat_ie_d  = HWDATA_I[7:0];
                        `IIE_OFF_IRQ_EN:  irq_en_d  = HWDATA_I[3:0];
                        default:          irq_en_d  = irq_en_q;
                    endcase
                end
            endcase
        end
        // (RULE17) set wins over write-one-to-clear
        pat_prev_d = pat_now;
        pat_flg_d  = (pat_flg_q & ~((addr_q == `IIE_OFF_PAT_FLG) & w1c[0])) | (pat_now & ~pat_prev_q);
        // (RULE8) change flag for enabled channels
        cos_flg_d  = (cos_flg_q & ~((addr_q == `IIE_OFF_COS_FLG) ? w1c[7:0] : 8'h00)) | (chg & cos_en_q);
        // (RULE11) wrap and match flags
        ovf_flg_d  = (ovf_flg_q & ~((addr_q == `IIE_OFF_OVF_FLG) ? w1c[7:0] : 8'h00)) | (ovf_ev & ovf_ie_q);
        mat_flg_d  = (mat_flg_q & ~((addr_q == `IIE_OFF_MAT_FLG) ? w1c[7:0] : 8'h00)) | (mat_ev & mat_ie_q);
    end

    // register stage of the register file
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            filt_en_q  <= 8'h00;
            pat_en_q   <= 8'h00;
            pat_val_q  <= 8'h00;
            cos_en_q   <= 8'h00;
            rise_en_q  <= 8'h00;
            fall_en_q  <= 8'h00;
            cnt_en_q   <= 8'h00;
            ovf_ie_q   <= 8'h00;
            mat_ie_q   <= 8'h00;
            irq_en_q   <= 4'h0;
            pat_prev_q <= 1'b0;
            pat_flg_q  <= 1'b0;
            cos_flg_q  <= 8'h00;
            ovf_flg_q  <= 8'h00;
            mat_flg_q  <= 8'h00;
            for (int i = 0; i < `IIE_NCH; i++) begin
                high_q[i] <= `IIE_SAMP_RST;
                low_q[i]  <= `IIE_SAMP_RST;
                rstv_q[i] <= `IIE_CNT_RST_VAL;
                matv_q[i] <= `IIE_MAT_RST_VAL;
            end
        end else if (CE_I) begin
            filt_en_q  <= filt_en_d;
            pat_en_q   <= pat_en_d;
            pat_val_q  <= pat_val_d;
            cos_en_q   <= cos_en_d;
            rise_en_q  <= rise_en_d;
            fall_en_q  <= fall_en_d;
            cnt_en_q   <= cnt_en_d;
            ovf_ie_q   <= ovf_ie_d;
            mat_ie_q   <= mat_ie_d;
            irq_en_q   <= irq_en_d;
            pat_prev_q <= pat_prev_d;
            pat_flg_q  <= pat_flg_d;
            cos_flg_q  <= cos_flg_d;
            ovf_flg_q  <= ovf_flg_d;
            mat_flg_q  <= mat_flg_d;
            high_q     <= high_d;
            low_q      <= low_d;
            rstv_q     <= rstv_d;
            matv_q     <= matv_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // (RULE17) request stays while any enabled flag is set
    assign IRQ_O = (irq_en_q[`IIE_IE_PAT] & pat_flg_q) | (irq_en_q[`IIE_IE_COS] & (|cos_flg_q)) |
                   (irq_en_q[`IIE_IE_OVF] & (|ovf_flg_q)) | (irq_en_q[`IIE_IE_MAT] & (|mat_flg_q));
    assign INPUT_CHANNEL_O = chan_st;

endmodule

// >>> src/iie_pkg.sv
// types for the isolated input event block
package iie_pkg;
    // ----------------------------------------------------------------
    // bus slave phase
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IIE_IDLE,
        IIE_WR,
        IIE_RD1,
        IIE_RD2
    } iie_phase_type;

    typedef logic [15:0] iie_word_type;
endpackage

// >>> src/iie_unused_placeholder_removed.sv
// intentionally empty design unit list: no further modules
`timescale 1ns/1ps
